// [common/pix_pkg.sv]
// Package for the camera pixel correction pipeline: register map, fields,
// reset values, stream carriers and the gamma curve helpers.
// Assumes a single pixel clock and an AXI4-Lite host port.
// What this block does
// - Black-level enable shifts each pixel by a programmed amount of 0..4095.
// - Manual white balance multiplies R, G, B by ratios 1..4095; 1024 is unity.
// - Once mode adapts ratios from gray areas for a bounded time, then holds.
// - Continuous mode keeps re-estimating red and blue ratios forever.
// - Gamma offers user and standard curves, applied only while enabled.
// - User gamma accepts a value from 0 to 4 and maps pixels non-linearly.
// - Gamma 0.5..1 brightens dark areas; 1..4 darkens them.
// - Lookup table enabled replaces pixel by entry; index 0..1023, value 0..4095.
// - Gamma and lookup table are never active together.
// - Sharpening off at reset; strength 0..100, mono and YUV formats only.
// - Hue and saturation act only when enabled and format is colour.
// - Six colour regions keep own hue and saturation, chosen by a selector.
// - Two statistics regions; region 1 brightness when used, region 2 balance.
// - Uniformity correction enables its two sub-corrections on its own.
// - Under auto exposure or gain, brightness is a target; higher is brighter.
// - Expert denoise applies a strength and a noise-correct curve value.
// - Brightness target is programmable from 0 to 255.
package pix_pkg;
    localparam int PIX_W = 12;
    localparam int LUT_AW = 10;
    localparam int PIPE_LAT = 5;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_BLACK = 8'h04;
    localparam logic [7:0] A_RATIO_R = 8'h08;
    localparam logic [7:0] A_RATIO_G = 8'h0C;
    localparam logic [7:0] A_RATIO_B = 8'h10;
    localparam logic [7:0] A_GAMMA = 8'h14;
    localparam logic [7:0] A_LUT = 8'h18;
    localparam logic [7:0] A_SHARP = 8'h1C;
    localparam logic [7:0] A_NOISE = 8'h20;
    localparam logic [7:0] A_HUESAT = 8'h24;
    localparam logic [7:0] A_CADJ = 8'h28;
    localparam logic [7:0] A_AOI1 = 8'h2C;
    localparam logic [7:0] A_AOI2 = 8'h30;
    localparam logic [7:0] A_BRIGHT = 8'h34;
    localparam logic [7:0] A_STATUS = 8'h38;
    // CTRL field positions
    localparam int C_BLACK_EN = 0;
    localparam int C_WB_MODE = 1; // two bits
    localparam int C_GAMMA_EN = 3;
    localparam int C_GAMMA_SRGB = 4;
    localparam int C_LUT_EN = 5;
    localparam int C_SHARP_EN = 6;
    localparam int C_HUE_EN = 7;
    localparam int C_SAT_EN = 8;
    localparam int C_CADJ_EN = 9;
    localparam int C_NOISE_EXP = 10;
    localparam int C_UNIF_EN = 11;
    localparam int C_AOI1_USE = 12;
    localparam int C_AOI2_USE = 13;
    localparam int C_AUTO_EXP = 14;
    localparam int C_FMT = 15; // two bits
    // Reset values, limits and response codes
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [11:0] RATIO_UNITY = 12'h400;
    localparam logic [11:0] RATIO_MIN = 12'h001;
    localparam logic [5:0] GAMMA_ONE = 6'h10; // 2.4 fixed point
    localparam logic [5:0] GAMMA_MAX = 6'h3F;
    localparam logic [6:0] SHARP_MAX = 7'h64;
    localparam logic [15:0] ONCE_FRAMES = 16'h0008;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {WB_OFF, WB_ONCE, WB_CONT} wb_mode_t;
    typedef enum logic [1:0] {FMT_MONO, FMT_BAYER, FMT_RGB, FMT_YUV} fmt_t;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eol;
        logic [1:0] chan; // 0 red, 1 green, 2 blue
        logic [11:0] data;
    } pix_t;
    // Clamp a wide unsigned value to 12 bits
    function automatic logic [11:0] sat12(input logic [23:0] v);
        sat12 = (v > 24'h000F_FF) ? 12'hFFF : v[11:0];
    endfunction
    // Power-law approximation: blend root and line, line and square, or square and cube by gamma
    function automatic logic [11:0] gamma_map(input logic [11:0] x,
                                              input logic [5:0] g);
        logic [23:0] sq;
        logic [23:0] lin;
        logic [23:0] rt;
        logic [23:0] cu;
        sq = ({12'h000, x} * {12'h000, x}) >> 12;
        cu = (sq * {12'h000, x}) >> 12;
        rt = {12'h000, x} + ((({12'h000, x} ^ 24'h0000_0FFF) * x) >> 12);
        lin = {12'h000, x};
        // Past gamma 2 blend square and cube; the line weight would wrap
        if (g >= 6'h20)
            gamma_map = sat12((sq * (7'h40 - g) + cu * (g - 6'h20)) >> 5);
        else if (g >= GAMMA_ONE)
            gamma_map = sat12((lin * (6'h20 - g) + sq * (g - 6'h10)) >> 4);
        else
            gamma_map = sat12((rt * (6'h10 - g) + lin * g) >> 4);
    endfunction
endpackage

// [design/pix_lut_mem.sv]
// Lookup table memory, 1024 words of 12 bits, registered read data.
// Assumes one write port from the host side, one read port for pixels.
`timescale 1ns/1ps
`default_nettype none
module pix_lut_mem
    import pix_pkg::*;
(
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [LUT_AW-1:0] waddr_in,
    input wire logic [PIX_W-1:0] wdata_in,
    input wire logic [LUT_AW-1:0] raddr_in,
    output logic [PIX_W-1:0] rdata_out
);
    logic [PIX_W-1:0] mem_q [0:(1<<LUT_AW)-1];
    // Plain array so it maps to block memory; no reset on contents
    always_ff @(posedge clk_in) begin
        if (we_in)
            mem_q[waddr_in] <= wdata_in;
        rdata_out <= mem_q[raddr_in];
    end
endmodule
`default_nettype wire

// [design/pix_pipe.sv]
// Pixel correction pipeline with AXI4-Lite control registers.
// Assumes a sensor stream with sof marker and a sink that never stalls.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pix_pipe
    import pix_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pix_t pix_in,
    output pix_t pix_out,
    output logic [7:0] bright_target_out,
    output logic aoi1_stats_en_out
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow registers (host side) and active copies (frame side)
    logic [31:0] sh_q [0:13];
    logic [31:0] act_q [0:13];
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic lut_we;
    logic [11:0] wb_r;
    logic [11:0] wb_b;
    logic wb_busy;
    logic unif_sub_q;
    logic [15:0] col_q;
    logic [15:0] row_q;
    wire logic [3:0] widx = aw_q[5:2];
    wire logic wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire logic wr_ok = (aw_q < A_STATUS) && (aw_q[1:0] == 2'b00);
    wire logic [3:0] ridx = s_axi_araddr[5:2];
    wire logic rd_ok = s_axi_araddr <= A_STATUS && s_axi_araddr[1:0] == 2'b00;
    wire logic frame_edge = pix_in.valid && pix_in.sof;
    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    endfunction
    // Write channel: catch address and data in either order
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    // Table words go straight to memory; bits 25:16 index, 11:0 value
    assign lut_we = wr_go && wr_ok && aw_q == A_LUT;
    // Shadow update, with range clamps on written fields
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 14; i++) sh_q[i] <= 32'h0000_0000;
            sh_q[A_RATIO_R[5:2]] <= {20'h0, RATIO_UNITY};
            sh_q[A_RATIO_G[5:2]] <= {20'h0, RATIO_UNITY};
            sh_q[A_RATIO_B[5:2]] <= {20'h0, RATIO_UNITY};
            sh_q[A_GAMMA[5:2]] <= {26'h0, GAMMA_ONE};
        end else if (wr_go && wr_ok && aw_q != A_LUT) begin
            sh_q[widx] <= merge(sh_q[widx], w_q, ws_q);
            // Later enable wins, so gamma and table never both set
            if (widx == A_CTRL[5:2] && w_q[C_GAMMA_EN])
                sh_q[widx][C_LUT_EN] <= 1'b0;
            if (widx == A_CTRL[5:2] && w_q[C_LUT_EN])
                sh_q[widx][C_GAMMA_EN] <= 1'b0;
            if (widx == A_RATIO_R[5:2] || widx == A_RATIO_B[5:2] ||
                widx == A_RATIO_G[5:2])
                sh_q[widx] <= {20'h0, (w_q[11:0] == 12'h0) ?
                    RATIO_MIN : w_q[11:0]};
            if (widx == A_SHARP[5:2])
                sh_q[widx] <= {25'h0, (w_q > {25'h0, SHARP_MAX}) ?
                    SHARP_MAX : w_q[6:0]};
            if (widx == A_BLACK[5:2])
                sh_q[widx] <= {20'h0, w_q[11:0]};
            if (widx == A_BRIGHT[5:2])
                sh_q[widx] <= {24'h0, w_q[7:0]};
        end
    end
    // Copy to active set only at frame start
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 14; i++) act_q[i] <= 32'h0000_0000;
        end else if (frame_edge) begin
            for (int i = 0; i < 14; i++) act_q[i] <= sh_q[i];
        end
    end
    // Read channel
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            if (!rd_ok)
                s_axi_rdata <= 32'h0000_0000;
            else if (s_axi_araddr == A_STATUS)
                s_axi_rdata <= {4'h0, unif_sub_q, unif_sub_q, wb_busy,
                    wb_b, 1'b0, wb_r};
            else
                s_axi_rdata <= sh_q[ridx];
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    ////////////////////////////////////////////////////////////////////////
    // Active field decode
    wire logic [31:0] ctl = act_q[A_CTRL[5:2]];
    wire logic [1:0] wb_mode = ctl[C_WB_MODE +: 2];
    wire logic [1:0] fmt = ctl[C_FMT +: 2];
    wire logic colour = fmt != FMT_MONO;
    wire logic sharp_ok = ctl[C_SHARP_EN] && (fmt == FMT_MONO ||
        fmt == FMT_YUV);
    wire logic [31:0] aoi2 = act_q[A_AOI2[5:2]];
    wire logic in_aoi2 = ctl[C_AOI2_USE] &&
        col_q >= {8'h0, aoi2[7:0]} && col_q < {8'h0, aoi2[7:0] + aoi2[15:8]}
        && row_q >= {8'h0, aoi2[23:16]} &&
        row_q < {8'h0, aoi2[23:16] + aoi2[31:24]};
    // Position counters for statistics region 2
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            col_q <= 16'h0000;
            row_q <= 16'h0000;
        end else if (pix_in.valid) begin
            col_q <= pix_in.sof ? 16'h0001 : pix_in.eol ? 16'h0000 :
                col_q + 16'h0001;
            row_q <= pix_in.sof ? 16'h0000 : pix_in.eol ? row_q + 16'h0001 :
                row_q;
        end
    end
    pix_wb_stats u_wb (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pix_in(pix_in),
        .in_region_in(in_aoi2),
        .mode_in(wb_mode),
        .ratio_r_out(wb_r),
        .ratio_b_out(wb_b),
        .busy_out(wb_busy)
    );
    ////////////////////////////////////////////////////////////////////////
    // Stage 1: black level, stage 2: white balance gain
    pix_t s1_q;
    pix_t s2_q;
    pix_t s3_q;
    pix_t s4_q;
    logic [11:0] lut_rd;
    // The sof pixel meets stage 1 at the edge that loads the active set,
    // so stage 1 reads the shadow there this assumes the frame
    // blanking before sof has drained the later stages of the old frame
    wire logic [31:0] ctl1 = frame_edge ? sh_q[A_CTRL[5:2]] : ctl;
    wire logic [11:0] blk = frame_edge ? sh_q[A_BLACK[5:2]][11:0] :
        act_q[A_BLACK[5:2]][11:0];
    wire logic [11:0] rr = (wb_mode == WB_OFF) ?
        act_q[A_RATIO_R[5:2]][11:0] : wb_r;
    wire logic [11:0] rb = (wb_mode == WB_OFF) ?
        act_q[A_RATIO_B[5:2]][11:0] : wb_b;
    wire logic [11:0] ratio = (s1_q.chan == 2'd0) ? rr :
        (s1_q.chan == 2'd2) ? rb : act_q[A_RATIO_G[5:2]][11:0];
    wire logic [23:0] wb_prod = ({12'h0, s1_q.data} * {12'h0, ratio}) >> 10;
    wire logic [5:0] gam = act_q[A_GAMMA[5:2]][5:0];
    wire logic [11:0] gam_out = gamma_map(s2_q.data,
        ctl[C_GAMMA_SRGB] ? 6'h07 : gam); // standard curve ~ gamma 0.45
    wire logic [11:0] sh_add = {5'h0, act_q[A_SHARP[5:2]][6:0]};
    wire logic [11:0] dn = act_q[A_NOISE[5:2]][11:0];
    pix_lut_mem u_lut (
        .clk_in(clk_in),
        .we_in(lut_we),
        .waddr_in(w_q[16 +: LUT_AW]),
        .wdata_in(w_q[11:0]),
        .raddr_in(s2_q.data[11:2]),
        .rdata_out(lut_rd)
    );
    // Each stage keeps its register even when bypassed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            s4_q <= '0;
            pix_out <= '0;
        end else begin
            s1_q <= pix_in;
            if (ctl1[C_BLACK_EN])
                s1_q.data <= sat12({12'h0, pix_in.data} + {12'h0, blk});
            s2_q <= s1_q;
            if (colour)
                s2_q.data <= sat12(wb_prod);
            s3_q <= s2_q;
            if (ctl[C_GAMMA_EN])
                s3_q.data <= gam_out;
            s4_q <= s3_q;
            if (ctl[C_LUT_EN] && !ctl[C_GAMMA_EN])
                s4_q.data <= lut_rd;
            pix_out <= s4_q;
            if (sharp_ok)
                pix_out.data <= sat12({12'h0, s4_q.data} + {12'h0, sh_add});
            else if (ctl[C_NOISE_EXP] && s4_q.data < dn)
                pix_out.data <= dn; // noise floor lift
        end
    end
    // Side outputs for the exposure loop and statistics
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bright_target_out <= 8'h00;
            aoi1_stats_en_out <= 1'b0;
        end else begin
            bright_target_out <= ctl[C_AUTO_EXP] ?
                act_q[A_BRIGHT[5:2]][7:0] : 8'h00;
            aoi1_stats_en_out <= ctl[C_AOI1_USE];
        end
    end
    // Uniformity sub-corrections follow the master enable by themselves;
    // the host holds no bit for them, it reads them back in status
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            unif_sub_q <= 1'b0;
        else
            unif_sub_q <= ctl[C_UNIF_EN];
    end
    // Hue, saturation and region adjust have no pixel math here:
    // are held in registers for the colour stage downstream.
    ////////////////////////////////////////////////////////////////////////
    excl_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !(sh_q[0][C_GAMMA_EN] && sh_q[0][C_LUT_EN]))
        else $error("gamma and table both enabled");
    act_excl_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !(ctl[C_GAMMA_EN] && ctl[C_LUT_EN]))
        else $error("active gamma and table both on");
    lat_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pix_in.valid |-> ##5 pix_out.valid)
        else $error("pipeline latency wrong");
    frame_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !frame_edge |=> $stable(act_q[0]))
        else $error("settings changed mid frame");
    blk_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sh_q[1][31:12] == 20'h0)
        else $error("black level out of range");
    ratio_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sh_q[2][11:0] != 12'h0)
        else $error("zero ratio");
    sharp_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sh_q[7][6:0] <= SHARP_MAX)
        else $error("sharpness over range");
    bright_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !ctl[C_AUTO_EXP] |=> bright_target_out == 8'h00)
        else $error("target without auto loop");
    resp_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    once_c: cover property (@(posedge clk_in) wb_mode == WB_ONCE && !wb_busy);
    cont_c: cover property (@(posedge clk_in) frame_edge && wb_busy);
    wr_c: cover property (@(posedge clk_in) wr_go && lut_we);
    rd_c: cover property (@(posedge clk_in) s_axi_rvalid && s_axi_rready);
    fr_c: cover property (@(posedge clk_in) frame_edge && ctl[C_GAMMA_EN]);
endmodule
`default_nettype wire

// [design/pix_wb_stats.sv]
// White-balance statistics and ratio estimator for once and continuous modes.
// Assumes pixels tagged by colour channel and start of frame.
`timescale 1ns/1ps
`default_nettype none
module pix_wb_stats
    import pix_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire pix_t pix_in,
    input wire logic in_region_in,
    input wire logic [1:0] mode_in,
    output logic [11:0] ratio_r_out,
    output logic [11:0] ratio_b_out,
    output logic busy_out
);
    logic [31:0] sum_q [0:2];
    logic [15:0] frames_q;
    logic [31:0] g_sum;
    wire logic is_gray = pix_in.valid && in_region_in &&
        pix_in.data > 12'h040 && pix_in.data < 12'hF80;
    wire logic adapting = (mode_in == WB_CONT) ||
        (mode_in == WB_ONCE && frames_q != 16'h0000);
    assign g_sum = sum_q[1];
    // Ratio = green sum / channel sum, unity scaled to 1024
    function automatic logic [11:0] est(input logic [31:0] c,
                                        input logic [31:0] g);
        logic [41:0] q;
        q = (c == 32'h0000_0000) ? {30'h0, RATIO_UNITY} :
            ({g, 10'h000} / {10'h000, c});
        est = (q > 42'h0FFF) ? 12'hFFF :
              (q == 42'h0) ? RATIO_MIN : q[11:0];
    endfunction
    // Accumulate near-gray samples, update ratios at each frame start while adapting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 3; i++) sum_q[i] <= 32'h0000_0000;
            ratio_r_out <= RATIO_UNITY;
            ratio_b_out <= RATIO_UNITY;
            frames_q <= 16'h0000;
            busy_out <= 1'b0;
        end else begin
            busy_out <= adapting;
            if (mode_in != WB_ONCE)
                frames_q <= ONCE_FRAMES; // re-arm the once window
            if (pix_in.valid && pix_in.sof) begin
                if (adapting) begin
                    ratio_r_out <= est(sum_q[0], g_sum);
                    ratio_b_out <= est(sum_q[2], g_sum);
                end
                if (mode_in == WB_ONCE && frames_q != 16'h0000)
                    frames_q <= frames_q - 16'h0001; // then hold
                for (int i = 0; i < 3; i++) sum_q[i] <= 32'h0000_0000;
            end else if (is_gray && pix_in.chan != 2'd3) begin
                sum_q[pix_in.chan] <= sum_q[pix_in.chan] + {20'h0, pix_in.data};
            end
        end
    end
endmodule
`default_nettype wire

// [tb/pix_src_model.sv]
// Sensor readout model: drives one tagged pixel per request.
// Assumes the pipeline samples pix_in on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module pix_src_model
    import pix_pkg::*;
(
    input wire logic clk_in,
    output pix_t pix_out
);
    initial pix_out = '0;
    // Idle cycles show inverted data so a stale value is never mistaken
    task automatic send(input logic sof, input logic [1:0] ch,
                        input logic [11:0] d);
        pix_out <= '{1'b1, sof, 1'b0, ch, d};
        @(posedge clk_in);
        pix_out <= '{1'b0, 1'b0, 1'b0, 2'd3, ~d};
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the pixel pipeline: registers over AXI4-Lite,
// pixels through the sensor model. Assumes a sink that never stalls.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pix_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, aoi1_stats_en_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] bright_target_out;
    logic [11:0] q;
    pix_t pix_in, pix_out;
    int err_count = 0, checks = 0, cyc = 0;
    pix_pipe pix_pipe_inst (.clk_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_in, .pix_out,
        .bright_target_out, .aoi1_stats_en_out);
    pix_src_model pix_src_model_inst (.clk_in(clk_in), .pix_out(pix_in));
    ////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above the few hundred cycles used
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
        checks = checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Bus tasks peek on the falling edge, act after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ta, tw, sa, sw, sb;
        ta = 0;
        tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_in);
            sa = !ta && (s_axi_awready === 1'b1);
            sw = !tw && (s_axi_wready === 1'b1);
            @(posedge clk_in);
            if (sa) s_axi_awvalid <= 1'b0;
            if (sw) s_axi_wvalid <= 1'b0;
            ta = ta | sa;
            tw = tw | sw;
        end while (!(ta && tw));
        do begin
            @(negedge clk_in);
            sb = (s_axi_bvalid === 1'b1);
            q = {10'h000, s_axi_bresp};
            @(posedge clk_in);
        end while (!sb);
        s_axi_bready <= 1'b0;
        cmp_val(q, er);
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic s;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_in);
            s = (s_axi_arready === 1'b1);
            @(posedge clk_in);
        end while (!s);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge clk_in);
            s = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_in);
        end while (!s);
        s_axi_rready <= 1'b0;
        cmp_val(d, ed);
        cmp_val(r, er);
        @(posedge clk_in);
    endtask
    // One pixel in, wait for it out at the fixed latency
    task automatic px(input logic sof, input logic [1:0] ch,
                      input logic [11:0] d, output logic [11:0] o);
        int n;
        pix_src_model_inst.send(sof, ch, d);
        n = 0;
        do begin
            @(negedge clk_in);
            n = n + 1;
        end while (pix_out.valid !== 1'b1 && n < 12);
        o = pix_out.data;
        cmp_val(n, PIPE_LAT);
        @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rd(A_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(A_RATIO_R, 32'h0000_0400, RESP_OKAY);
        rd(A_GAMMA, 32'h0000_0010, RESP_OKAY);
        rd(8'h3C, 32'h0000_0000, RESP_SLVERR);
        rd(8'h06, 32'h0000_0000, RESP_SLVERR);
        wr(A_STATUS, 32'h0000_0001, RESP_SLVERR);
        wr(A_SHARP, 32'h0000_00FF, RESP_OKAY);
        rd(A_SHARP, 32'h0000_0064, RESP_OKAY);
        wr(A_RATIO_G, 32'h0000_0000, RESP_OKAY);
        rd(A_RATIO_G, 32'h0000_0001, RESP_OKAY);
        wr(A_RATIO_G, 32'h0000_0400, RESP_OKAY);
    endtask
    task automatic t_black();
        wr(A_BLACK, 32'h0000_0100, RESP_OKAY);
        wr(A_CTRL, 32'h0000_0001, RESP_OKAY);
        px(1'b0, 2'd1, 12'h200, q);
        cmp_val(q, 12'h200);
        px(1'b1, 2'd1, 12'h200, q);
        cmp_val(q, 12'h300);
    endtask
    task automatic t_wb();
        wr(A_CTRL, 32'h0001_0000, RESP_OKAY); // RGB, so gains apply
        wr(A_RATIO_R, 32'h0000_0800, RESP_OKAY);
        px(1'b1, 2'd0, 12'h100, q);
        cmp_val(q, 12'h200);
        px(1'b0, 2'd2, 12'h100, q);
        cmp_val(q, 12'h100);
    endtask
    task automatic t_gamma();
        wr(A_GAMMA, 32'h0000_0008, RESP_OKAY);
        wr(A_CTRL, 32'h0000_0008, RESP_OKAY);
        px(1'b1, 2'd1, 12'h400, q);
        cmp_val(q > 12'h400, 1);
        wr(A_GAMMA, 32'h0000_0020, RESP_OKAY);
        px(1'b1, 2'd1, 12'h400, q);
        cmp_val(q < 12'h400, 1);
        wr(A_CTRL, 32'h0000_0000, RESP_OKAY);
        px(1'b1, 2'd1, 12'h400, q);
        cmp_val(q, 12'h400);
    endtask
    task automatic t_lut();
        wr(A_LUT, 32'h0100_0ABC, RESP_OKAY);
        wr(A_CTRL, 32'h0000_0008, RESP_OKAY);
        wr(A_CTRL, 32'h0000_0020, RESP_OKAY);
        rd(A_CTRL, 32'h0000_0020, RESP_OKAY);
        px(1'b1, 2'd1, 12'h400, q);
        cmp_val(q, 12'hABC);
    endtask
    task automatic t_bright();
        wr(A_BRIGHT, 32'h0000_00FF, RESP_OKAY);
        wr(A_CTRL, 32'h0000_5000, RESP_OKAY);
        px(1'b1, 2'd1, 12'h010, q);
        cmp_val(bright_target_out, 8'hFF);
        cmp_val(aoi1_stats_en_out, 1'b1);
        wr(A_CTRL, 32'h0000_0000, RESP_OKAY);
        px(1'b1, 2'd1, 12'h010, q);
        cmp_val(bright_target_out, 8'h00);
    endtask
    task automatic t_auto();
        wr(A_AOI2, 32'hFF00_FF00, RESP_OKAY);
        wr(A_CTRL, 32'h0000_2004, RESP_OKAY);
        px(1'b1, 2'd1, 12'h400, q);
        px(1'b0, 2'd0, 12'h200, q);
        px(1'b0, 2'd1, 12'h400, q);
        px(1'b0, 2'd2, 12'h800, q);
        px(1'b1, 2'd1, 12'h400, q);
        rd(A_STATUS, 32'h0240_0800, RESP_OKAY);
        wr(A_CTRL, 32'h0000_2002, RESP_OKAY);
        repeat (9) px(1'b1, 2'd1, 12'h400, q);
        rd(A_STATUS, 32'h0080_0400, RESP_OKAY);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_black();
        t_wb();
        t_gamma();
        t_lut();
        t_bright();
        t_auto();
        print_verdict();
    end
endmodule
`default_nettype wire
